// *** src/adc_spi_defs.vh ***
/*
 * Shared constants of the ADC serial frame interface: word sizes, frame
 * layout, command codes, ready-source encodings and timing counts.
 * Assumes plain Verilog-2005 and inclusion by bare name.
 */
`ifndef ADC_SPI_DEFS_VH
`define ADC_SPI_DEFS_VH

// Word size selector encodings
`define WSZ_16              2'h0
`define WSZ_24              2'h1
`define WSZ_32_PAD          2'h2
`define WSZ_32_SEXT         2'h3
`define WSZ_RESET           2'h1

// Word bit counts
`define BITS_16             6'h10
`define BITS_24             6'h18
`define BITS_32             6'h20

// Frame layout: response, eight channels, output check word
`define NUM_CH              8
`define WORDS_STD           7'h0a
`define WORD_CRC            7'h09

// Command codes and masks
`define CMD_NOOP            16'h0000
`define CMD_RD_MASK         16'he000
`define CMD_RD_CODE         16'ha000
`define CMD_WR_CODE         16'h6000
`define CMD_ACK_MULTI       16'h4000
`define CMD_WR_ACK          16'h4000
`define CMD_CNT_MASK        16'h007f

// Ready source selections
`define SRC_LAG             2'h0
`define SRC_ANY             2'h1

// Phase boundaries for first ready per oversampling ratio
`define OSR_128             3'h0
`define OSR_256             3'h1
`define OSR_512             3'h2
`define OSR_1024            3'h3
`define BND_128             10'h3ed
`define BND_256             10'h3ad
`define BND_512             10'h32d
`define BND_1024            10'h22d

// Frame timeout in master clock cycles
`define TIMEOUT_CYC         32768

// Ready pulse width in system clocks
`define PULSE_CYC           4'h4

`endif

// *** src/sample_fifo.v ***
/*
 * Synchronous FIFO with valid/ready on both sides and parameterised width
 * and depth. Assumes a single clock and an active-low asynchronous reset.
 */
module sample_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_resetn,
	// Fill side
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	// Drain side
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data,
	output wire [AW:0]      o_level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_ptr;
	reg [AW:0]      rd_ptr;
	wire            push;
	wire            pop;

	assign o_level     = wr_ptr - rd_ptr;
	assign o_in_ready  = (o_level != DEPTH[AW:0]);
	assign o_out_valid = (o_level != {(AW+1){1'b0}});
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	// Head word read straight from the flip-flop array, no extra latency
	assign o_out_data  = mem[rd_ptr[AW-1:0]];

	always @(posedge i_clk) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= i_in_data;
	end

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// *** src/adc_spi_frame_interface.v ***
/*
 * Serial frame interface of an eight-channel converter: mode-1 slave shift
 * logic, frame sequencing, data-ready generation and frame timeout.
 * Assumes conversion results arrive on i_clk as a valid/ready stream of
 * channel-tagged samples, and that the command decoder outside consumes
 * o_cmd and supplies register read words and the response word.
 */
`include "adc_spi_defs.vh"

module adc_spi_frame_interface #(
	parameter TIMEOUT_CYCLES = `TIMEOUT_CYC,
	parameter FIFO_DEPTH     = 16,
	parameter FIFO_AW        = 4
) (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_resetn,
	// Serial link pins
	input  wire        i_sclk,
	input  wire        i_cs_n,
	input  wire        i_din,
	output reg         o_dout,
	output reg         o_dout_oe,
	// Data-ready pin (open-drain capable)
	output wire        o_data_ready_n,
	output wire        o_data_ready_oe,
	// Master clock input, sampled for the timeout
	input  wire        i_master_clock_in,
	// Configuration
	input  wire [1:0]  i_word_size_sel,
	input  wire        i_word_size_valid,
	input  wire [1:0]  i_ready_source_sel,
	input  wire        i_ready_drive_sel,
	input  wire        i_ready_format_sel,
	input  wire        i_timeout_en,
	input  wire        i_global_chop,
	input  wire        i_current_detect,
	input  wire        i_cd_event,
	input  wire [2:0]  i_oversampling_ratio,
	input  wire [79:0] i_channel_phase_setting,
	input  wire        i_chan_restart,
	// Conversion sample stream
	input  wire        i_smp_valid,
	output wire        o_smp_ready,
	input  wire [2:0]  i_smp_ch,
	input  wire [23:0] i_smp_data,
	// Command decoder side
	output reg  [15:0] o_cmd,
	output reg         o_cmd_valid,
	output reg  [15:0] o_wr_data,
	output reg         o_wr_valid,
	input  wire [15:0] i_resp_word,
	input  wire [15:0] i_reg_rd_word,
	input  wire [15:0] i_out_crc,
	// Status
	output reg  [7:0]  o_status_new
);
	// Two-flop synchronisers
	reg [1:0] sclk_s;
	reg [1:0] cs_s;
	reg [1:0] din_s;
	reg [1:0] mclk_s;
	reg       sclk_d;
	reg       cs_d;
	reg       mclk_d;
	wire      sclk_rise = sclk_s[1] & ~sclk_d;
	wire      sclk_fall = ~sclk_s[1] & sclk_d;
	wire      cs_rise   = cs_s[1] & ~cs_d;
	wire      mclk_rise = mclk_s[1] & ~mclk_d;
	wire      active    = ~cs_s[1];

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sclk_s <= 2'h0;
			cs_s   <= 2'h3;
			din_s  <= 2'h0;
			mclk_s <= 2'h0;
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
			mclk_d <= 1'b0;
		end else begin
			sclk_s <= {sclk_s[0], i_sclk};
			cs_s   <= {cs_s[0], i_cs_n};
			din_s  <= {din_s[0], i_din};
			mclk_s <= {mclk_s[0], i_master_clock_in};
			sclk_d <= sclk_s[1];
			cs_d   <= cs_s[1];
			mclk_d <= mclk_s[1];
		end
	end

	// Word size, latched so a change never splits a frame
	reg [1:0] wsize;
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			wsize <= `WSZ_RESET;
		else if (i_word_size_valid && !active)
			wsize <= i_word_size_sel;
	end

	function [5:0] word_bits;
		input [1:0] ws;
		begin
			case (ws)
			`WSZ_16: word_bits = `BITS_16;
			`WSZ_24: word_bits = `BITS_24;
			default: word_bits = `BITS_32;
			endcase
		end
	endfunction

	// Left-aligned 16-bit control word in a 32-bit shift image
	function [31:0] ctl_word;
		input [15:0] w;
		begin
			ctl_word = {w, 16'h0000};
		end
	endfunction

	// Conversion sample placed in a 32-bit shift image
	function [31:0] data_word;
		input [1:0]  ws;
		input [23:0] d;
		begin
			case (ws)
			`WSZ_16:     data_word = {d[23:8], 16'h0000};
			`WSZ_24:     data_word = {d, 8'h00};
			`WSZ_32_PAD: data_word = {d, 8'h00};
			default:     data_word = {{8{d[23]}}, d};
			endcase
		end
	endfunction

	// Sample buffering: shared FIFO feeds two-deep per-channel slots
	wire        fq_valid;
	wire        fq_ready;
	wire [26:0] fq_data;
	wire [FIFO_AW:0] fq_level;
	sample_fifo #(.WIDTH(27), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
		.i_clk       (i_clk),
		.i_resetn    (i_resetn),
		.i_in_valid  (i_smp_valid),
		.o_in_ready  (o_smp_ready),
		.i_in_data   ({i_smp_ch, i_smp_data}),
		.o_out_valid (fq_valid),
		.i_out_ready (fq_ready),
		.o_out_data  (fq_data),
		.o_level     (fq_level)
	);

	reg [23:0] slot0 [0:`NUM_CH-1];
	reg [23:0] slot1 [0:`NUM_CH-1];
	reg [1:0]  cnt   [0:`NUM_CH-1];
	reg [7:0]  rd_ch; // Channels shifted out in this frame
	reg        frame_done;
	wire [2:0] in_ch = fq_data[26:24];
	// Slots full stall the FIFO, which stalls the sample source
	assign fq_ready = (cnt[in_ch] != 2'h2) && !frame_done;

	genvar g;
	generate
		for (g = 0; g < `NUM_CH; g = g + 1) begin : g_ch
			wire wr = fq_valid && fq_ready && (in_ch == g);
			wire rd = frame_done && rd_ch[g] && (cnt[g] != 2'h0);
			always @(posedge i_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					cnt[g]   <= 2'h0;
					slot0[g] <= 24'h000000;
					slot1[g] <= 24'h000000;
				end else if (i_chan_restart) begin
					cnt[g] <= 2'h0;
				end else if (rd) begin
					slot0[g] <= slot1[g];
					cnt[g]   <= cnt[g] - 2'h1;
				end else if (wr) begin
					if (cnt[g] == 2'h0)
						slot0[g] <= fq_data[23:0];
					else
						slot1[g] <= fq_data[23:0];
					cnt[g] <= cnt[g] + 2'h1;
				end
			end
			always @(posedge i_clk or negedge i_resetn) begin
				if (!i_resetn)
					o_status_new[g] <= 1'b0;
				else
					o_status_new[g] <= (cnt[g] != 2'h0);
			end
		end
	endgenerate

	// Ready source: governing channel from phase settings
	reg [2:0] lag_ch;
	reg [2:0] lead_ch;
	reg [2:0] gov_ch;
	integer   k;
	always @* begin
		lag_ch  = 3'h0;
		lead_ch = 3'h0;
		for (k = 1; k < `NUM_CH; k = k + 1) begin
			if ($signed(i_channel_phase_setting[k*10 +: 10]) >
			    $signed(i_channel_phase_setting[lag_ch*10 +: 10]))
				lag_ch = k[2:0];
			if ($signed(i_channel_phase_setting[k*10 +: 10]) <
			    $signed(i_channel_phase_setting[lead_ch*10 +: 10]))
				lead_ch = k[2:0];
		end
		gov_ch = (i_ready_source_sel == `SRC_LAG) ? lag_ch : lead_ch;
	end

	// Boundary check for the first ready after enable or sync
	reg [9:0] bnd;
	reg       bnd_none;
	always @* begin
		bnd_none = 1'b0;
		case (i_oversampling_ratio)
		`OSR_128:  bnd = `BND_128;
		`OSR_256:  bnd = `BND_256;
		`OSR_512:  bnd = `BND_512;
		`OSR_1024: bnd = `BND_1024;
		default: begin
			bnd      = `BND_128;
			bnd_none = 1'b1;
		end
		endcase
	end
	wire [9:0] gov_ph    = i_channel_phase_setting[gov_ch*10 +: 10];
	wire       first_now = !bnd_none && ($signed(gov_ph) > $signed(bnd));

	// Ready event: a sample accepted into the slots, from the governing channel unless chop or the any source is set
	wire acc    = fq_valid && fq_ready;
	wire any_ev = acc && (i_global_chop ||
		i_ready_source_sel == `SRC_ANY || in_ch == gov_ch);
	reg  first_pend;
	reg  skip_first;
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			first_pend <= 1'b0;
			skip_first <= 1'b0;
		end else if (i_chan_restart) begin
			first_pend <= 1'b1;
			skip_first <= 1'b0;
		end else if (first_pend && any_ev) begin
			first_pend <= 1'b0;
			skip_first <= !first_now && !i_global_chop;
		end else if (skip_first && any_ev) begin
			skip_first <= 1'b0;
		end
	end
	wire ready_ev = any_ev && !(first_pend && !first_now && !i_global_chop)
		&& !skip_first;

	// Frame state
	reg [5:0]  bitn;
	reg [6:0]  wordn;
	reg [6:0]  nwords;
	reg [31:0] tx_sh;
	reg [31:0] rx_sh;
	reg [15:0] pend_cmd;
	reg        rd_multi;
	reg [6:0]  rd_cnt;
	wire [5:0] wbits = word_bits(wsize);
	// Control word as it stands once the current bit is shifted in
	wire [15:0] rx_now = rx_word(wbits, {rx_sh[30:0], din_s[1]});
	wire       reading = active && (wordn != 7'h0 || bitn != 6'h0);

	// Data-ready generation
	reg        data_ready_n_low;
	reg [3:0]  pulse_cnt;
	reg        unread;
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			data_ready_n_low  <= 1'b0;
			pulse_cnt <= 4'h0;
			unread    <= 1'b0;
		end else begin
			if (pulse_cnt != 4'h0)
				pulse_cnt <= pulse_cnt - 4'h1;
			if (i_current_detect) begin
				data_ready_n_low <= i_cd_event;
			end else if (ready_ev && !reading) begin
				if (i_ready_format_sel) begin
					if (unread)
						unread <= 1'b0;
					else begin
						pulse_cnt <= `PULSE_CYC;
						unread    <= 1'b1;
					end
				end else
					data_ready_n_low <= 1'b1;
			end else if (frame_done && rd_ch != 8'h00) begin
				data_ready_n_low <= 1'b0;
				unread   <= 1'b0;
			end
		end
	end
	wire data_ready_n_assert = data_ready_n_low || (pulse_cnt != 4'h0);
	assign o_data_ready_n  = !data_ready_n_assert;
	assign o_data_ready_oe = data_ready_n_assert || !i_ready_drive_sel;

	// Timeout counted on master clock edges within a frame
	reg [15:0] to_cnt;
	reg        to_run;
	wire       to_hit = i_timeout_en && to_run &&
		(to_cnt >= TIMEOUT_CYCLES[15:0]);
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			to_cnt <= 16'h0000;
			to_run <= 1'b0;
		end else if (cs_rise || to_hit) begin
			to_cnt <= 16'h0000;
			to_run <= 1'b0;
		end else begin
			if (active && sclk_rise)
				to_run <= 1'b1;
			if (to_run && mclk_rise)
				to_cnt <= to_cnt + 16'h0001;
		end
	end

	// Output word for a given index
	reg [31:0] next_tx;
	always @* begin
		next_tx = 32'h00000000;
		if (wordn == 7'h0)
			next_tx = ctl_word(i_resp_word);
		else if (rd_multi && wordn <= rd_cnt)
			next_tx = ctl_word(i_reg_rd_word);
		else if (wordn == nwords - 7'h1)
			next_tx = ctl_word(i_out_crc);
		else if (wordn - (rd_multi ? rd_cnt : 7'h0) <= 7'h8)
			next_tx = data_word(wsize,
				slot0[wordn[2:0] - 3'h1 - rd_cnt[2:0]]);
	end

	// Shift engine
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bitn        <= 6'h00;
			wordn       <= 7'h00;
			nwords      <= `WORDS_STD;
			tx_sh       <= 32'h00000000;
			rx_sh       <= 32'h00000000;
			pend_cmd    <= `CMD_NOOP;
			rd_multi    <= 1'b0;
			rd_cnt      <= 7'h00;
			rd_ch       <= 8'h00;
			frame_done  <= 1'b0;
			o_cmd       <= `CMD_NOOP;
			o_cmd_valid <= 1'b0;
			o_wr_data   <= 16'h0000;
			o_wr_valid  <= 1'b0;
			o_dout      <= 1'b0;
			o_dout_oe   <= 1'b0;
		end else begin
			o_cmd_valid <= 1'b0;
			o_wr_valid  <= 1'b0;
			frame_done  <= 1'b0;
			o_dout_oe   <= active && !to_hit;
			if (cs_rise || to_hit) begin
				if (wordn >= nwords && pend_cmd != `CMD_NOOP) begin
					o_cmd       <= pend_cmd;
					o_cmd_valid <= 1'b1;
				end
				frame_done <= (wordn >= nwords);
				bitn       <= 6'h00;
				wordn      <= 7'h00;
				nwords     <= `WORDS_STD;
				pend_cmd   <= `CMD_NOOP;
				rd_multi   <= 1'b0;
				rd_cnt     <= 7'h00;
			end else if (!active) begin
				rd_ch <= frame_done ? 8'h00 : rd_ch;
			end else if (sclk_rise) begin
				if (bitn == 6'h00) begin
					o_dout <= next_tx[31];
					tx_sh  <= {next_tx[30:0], 1'b0};
				end else begin
					o_dout <= tx_sh[31];
					tx_sh  <= {tx_sh[30:0], 1'b0};
				end
			end else if (sclk_fall) begin
				rx_sh <= {rx_sh[30:0], din_s[1]};
				if (bitn == wbits - 6'h1) begin
					bitn  <= 6'h00;
					wordn <= wordn + 7'h1;
					if (wordn != 7'h0 && !rd_multi &&
					    wordn <= 7'h8)
						rd_ch[wordn[2:0] - 3'h1] <= 1'b1;
					if (wordn == 7'h0) begin
						pend_cmd <= rx_sh[14:0] == 15'h0 && wbits == 6'h0 ?
							`CMD_NOOP : rx_word(wbits, {rx_sh[30:0], din_s[1]});
						if ((rx_now & `CMD_RD_MASK) == `CMD_WR_CODE)
							nwords <= `WORDS_STD + rx_now[6:0];
					end else if ((pend_cmd & `CMD_RD_MASK) == `CMD_WR_CODE
						&& wordn < nwords - `WORD_CRC) begin
						o_wr_data  <= rx_word(wbits, {rx_sh[30:0], din_s[1]});
						o_wr_valid <= 1'b1;
					end
				end else
					bitn <= bitn + 6'h1;
			end
		end
	end

	// Top 16 bits of a received word of the current size
	function [15:0] rx_word;
		input [5:0]  nb;
		input [31:0] sh;
		begin
			case (nb)
			`BITS_16: rx_word = sh[15:0];
			`BITS_24: rx_word = sh[23:8];
			default:  rx_word = sh[31:16];
			endcase
		end
	endfunction
endmodule

// *** dv/adc_spi_frame_interface_chk.sv ***
/*
 * Port-level timing checker for the serial frame interface.
 * Assumes it is bound onto the interface top and sees one clock domain.
 */
module adc_spi_frame_interface_chk (
	// Clock and reset
	input logic i_clk,
	input logic i_resetn,
	// Link and configuration inputs
	input logic i_sclk,
	input logic i_cs_n,
	input logic i_timeout_en,
	input logic i_ready_drive_sel,
	input logic i_ready_format_sel,
	// Watched outputs
	input logic o_dout,
	input logic o_dout_oe,
	input logic o_data_ready_n,
	input logic o_data_ready_oe,
	input logic o_cmd_valid
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	a_out_released: assert property (i_cs_n [*8] |-> !o_dout_oe)
		else $error("data output enabled while deselected");
	a_out_driven: assert property ($fell(i_cs_n) |-> ##[1:6] o_dout_oe)
		else $error("data output not enabled in frame");
	// A timeout may restart a word mid-frame, so it is left out here
	a_out_launch: assert property (o_dout_oe && $past(o_dout_oe) &&
		!i_timeout_en && $changed(o_dout) |-> $past(i_sclk, 3))
		else $error("data output moved away from a clock rise");
	a_cmd_single: assert property (o_cmd_valid |=> !o_cmd_valid)
		else $error("command strobe longer than one cycle");
	a_cmd_frame_end: assert property (o_cmd_valid |-> i_cs_n && $past(i_cs_n, 2))
		else $error("command taken before the frame ended");
	a_ready_driven: assert property (!o_data_ready_n |-> o_data_ready_oe)
		else $error("asserted ready not driven");
	a_ready_push: assert property ((!i_ready_drive_sel) [*3] |-> o_data_ready_oe)
		else $error("push-pull ready not driven");
	a_ready_open: assert property (i_ready_drive_sel [*3] ##0 o_data_ready_n
		|-> !o_data_ready_oe)
		else $error("open-drain ready driven while idle");
	a_ready_pulse: assert property (i_ready_format_sel [*3] ##0
		$fell(o_data_ready_n) |-> !o_data_ready_n [*4] ##1 o_data_ready_n)
		else $error("ready pulse width wrong");
endmodule

bind adc_spi_frame_interface adc_spi_frame_interface_chk
	adc_spi_frame_interface_chk_i (.i_clk, .i_resetn, .i_sclk, .i_cs_n,
	.i_timeout_en, .i_ready_drive_sel, .i_ready_format_sel, .o_dout,
	.o_dout_oe, .o_data_ready_n, .o_data_ready_oe, .o_cmd_valid);

// *** dv/spi_host_model.sv ***
/*
 * Host side of the serial link: a mode-1 master with frame tasks.
 * Assumes the bench clock paces every edge, high for 4 clocks and low for 5.
 */
module spi_host_model (
	// Clock
	input  logic i_clk,
	// Serial link
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_din,
	input  logic i_dout,
	input  logic i_dout_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] got [0:9];
	logic        last = 1'b0;
	logic        line;

	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_din = 1'b0;
	end
	// The data line has no pull, so a released line shows the inverse
	assign line = i_dout_oe ? i_dout : ~last;
	always @(posedge i_clk)
		if (i_dout_oe)
			last <= i_dout;

	task automatic sel(input logic v);
		@(posedge i_clk);
		o_cs_n <= v;
		if (v)
			o_din <= ~o_din;
		repeat (8) @(posedge i_clk);
	endtask

	// Bits are read late in the low phase, where the output still stands
	task automatic shift(input logic [31:0] w, input int nb,
		output logic [31:0] r);
		r = 32'h0;
		for (int i = nb - 1; i >= 0; i--) begin
			@(posedge i_clk);
			o_sclk <= 1'b1;
			o_din <= w[i];
			repeat (4) @(posedge i_clk);
			o_sclk <= 1'b0;
			repeat (4) @(posedge i_clk);
			r[i] = line;
		end
	endtask

	task automatic frame(input logic [15:0] cmd, input int nb);
		sel(1'b0);
		for (int k = 0; k < 10; k++)
			shift(k == 0 ? {16'h0, cmd} << (nb - 16) : 32'h0, nb, got[k]);
		sel(1'b1);
	endtask
endmodule

// *** dv/adc_spi_frame_interface_test.sv ***
/*
 * Self-checking bench for the serial frame interface.
 * Assumes the host model drives the link; other inputs are driven here.
 */
module adc_spi_frame_interface_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        i_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic        i_master_clock_in = 1'b0;
	logic [1:0]  mdiv = 2'h0;
	logic        i_word_size_valid = 1'b0;
	logic        i_ready_drive_sel = 1'b0;
	logic        i_ready_format_sel = 1'b0;
	logic        i_timeout_en = 1'b0;
	logic        i_chan_restart = 1'b0;
	logic        i_smp_valid = 1'b0;
	logic [1:0]  i_word_size_sel = 2'h1;
	logic [1:0]  i_ready_source_sel = 2'h1;
	logic [2:0]  i_smp_ch = 3'h0;
	logic [23:0] i_smp_data = 24'h0;
	logic [15:0] i_resp_word = 16'h0;
	logic [15:0] i_reg_rd_word = 16'h0;
	logic [15:0] i_out_crc = 16'h0;
	// Held constant: no chop, no current detect, zero phase settings
	logic        i_global_chop = 1'b0;
	logic        i_current_detect = 1'b0;
	logic        i_cd_event = 1'b0;
	logic [2:0]  i_oversampling_ratio = 3'h0;
	logic [79:0] i_channel_phase_setting = 80'h0;
	logic        i_sclk, i_cs_n, i_din, o_dout, o_dout_oe;
	logic        o_data_ready_n, o_data_ready_oe, o_smp_ready, o_cmd_valid;
	logic [15:0] o_cmd;
	logic [15:0] last_cmd = 16'h0;
	logic [7:0]  o_status_new;
	logic [31:0] g [0:9];
	int          miscompares = 0;
	int          checks = 0;
	int          ncmd = 0;
	// Open-drain ready pin has a pull-up
	wire         data_ready_n_line = o_data_ready_oe ? o_data_ready_n : 1'b1;

	always #20 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		mdiv <= mdiv + 2'h1;
		i_master_clock_in <= mdiv[1];
	end
	always @(posedge i_clk)
		if (o_cmd_valid) begin
			last_cmd <= o_cmd;
			ncmd <= ncmd + 1;
		end

	adc_spi_frame_interface #(.TIMEOUT_CYCLES(1024)) adc_spi_frame_interface_i (
		.i_clk, .i_resetn, .i_sclk, .i_cs_n, .i_din, .o_dout, .o_dout_oe,
		.o_data_ready_n, .o_data_ready_oe, .i_master_clock_in,
		.i_word_size_sel, .i_word_size_valid, .i_ready_source_sel,
		.i_ready_drive_sel, .i_ready_format_sel, .i_timeout_en,
		.i_global_chop, .i_current_detect, .i_cd_event,
		.i_oversampling_ratio, .i_channel_phase_setting, .i_chan_restart,
		.i_smp_valid, .o_smp_ready, .i_smp_ch, .i_smp_data, .o_cmd,
		.o_cmd_valid, .o_wr_data(), .o_wr_valid(), .i_resp_word,
		.i_reg_rd_word, .i_out_crc, .o_status_new);
	spi_host_model spi_host_model_i (.i_clk, .o_sclk(i_sclk),
		.o_cs_n(i_cs_n), .o_din(i_din), .i_dout(o_dout),
		.i_dout_oe(o_dout_oe));

	task automatic chk(input string what, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	function automatic logic [23:0] smp(input int c, input logic [23:0] s);
		return 24'h9a5c30 ^ 24'(c << 21) ^ s;
	endfunction

	function automatic logic [31:0] fmt(input logic [1:0] ws,
		input logic [23:0] d);
		case (ws)
			2'h0: return {16'h0, d[23:8]};
			2'h2: return {d, 8'h0};
			2'h3: return {{8{d[23]}}, d};
			default: return {8'h0, d};
		endcase
	endfunction

	task automatic wait_data_ready_n(input logic v, output int n);
		for (n = 0; data_ready_n_line !== v; n++) begin
			if (n == 80) begin
				chk("ready wait", {31'h0, data_ready_n_line}, {31'h0, v});
				results;
			end
			@(posedge i_clk);
		end
	endtask

	task automatic push(input int c, input logic [23:0] d, output logic ok);
		ok = 1'b0;
		@(posedge i_clk);
		i_smp_valid <= 1'b1;
		i_smp_ch <= c[2:0];
		i_smp_data <= d;
		for (int n = 0; n < 20 && !ok; n++) begin
			@(posedge i_clk);
			ok = o_smp_ready;
		end
		i_smp_valid <= 1'b0;
	endtask

	task automatic push8(input logic [23:0] s);
		logic ok;
		for (int c = 0; c < 8; c++) begin
			push(c, smp(c, s), ok);
			chk("sample taken", {31'h0, ok}, 32'h1);
		end
		repeat (4) @(posedge i_clk);
	endtask

	task automatic set_size(input logic [1:0] ws);
		@(posedge i_clk);
		i_word_size_sel <= ws;
		i_word_size_valid <= 1'b1;
		@(posedge i_clk);
		i_word_size_valid <= 1'b0;
	endtask

	task automatic read_check(input logic [15:0] cmd, input int nb,
		input logic [1:0] ws, input logic [23:0] s);
		logic [15:0] resp;
		logic [15:0] crc;
		resp = 16'hc3a0 ^ cmd;
		crc = 16'h5e01 + cmd;
		i_resp_word <= resp;
		i_out_crc <= crc;
		i_reg_rd_word <= ~cmd;
		spi_host_model_i.frame(cmd, nb);
		repeat (8) @(posedge i_clk);
		g = spi_host_model_i.got;
		chk("response", g[0], {16'h0, resp} << (nb - 16));
		chk("output check", g[9], {16'h0, crc} << (nb - 16));
		for (int c = 0; c < 8; c++)
			chk("channel data", g[c + 1], fmt(ws, smp(c, s)));
		chk("command", {16'h0, last_cmd}, {16'h0, cmd});
	endtask

	task automatic t_reset;
		chk("output enable", {31'h0, o_dout_oe}, 32'h0);
		chk("ready pin", {31'h0, data_ready_n_line}, 32'h1);
		chk("status", {24'h0, o_status_new}, 32'h0);
		$display("reset test done");
	endtask

	task automatic t_frames;
		logic [1:0]  wl [0:3] = '{2'h1, 2'h0, 2'h2, 2'h3};
		int          nbl [0:3] = '{24, 16, 32, 32};
		logic [15:0] cl [0:3] = '{16'h0000, 16'h0022, 16'h0033, 16'h0555};
		for (int i = 0; i < 4; i++) begin
			if (i > 0)
				set_size(wl[i]);
			push8(24'(i));
			chk("new flags", {24'h0, o_status_new}, 32'hff);
			read_check(cl[i], nbl[i], wl[i], 24'(i));
			chk("flags read", {24'h0, o_status_new}, 32'h0);
		end
		set_size(2'h1);
		$display("word size test done");
	endtask

	task automatic t_abort;
		logic [31:0] r;
		int          n0;
		n0 = ncmd;
		spi_host_model_i.sel(1'b0);
		spi_host_model_i.shift(32'h1a, 5, r);
		spi_host_model_i.sel(1'b1);
		chk("dropped command", ncmd, n0);
		push8(24'h0f0f0);
		read_check(16'h0655, 24, 2'h1, 24'h0f0f0);
		chk("frame count", ncmd, n0 + 1);
		$display("abort test done");
	endtask

	task automatic t_ready;
		logic [1:0] src [0:3] = '{2'h0, 2'h2, 2'h3, 2'h1};
		logic       ok;
		int         n;
		for (int i = 0; i < 5; i++) begin
			@(posedge i_clk);
			i_chan_restart <= 1'b1;
			i_ready_source_sel <= src[i % 4];
			i_ready_format_sel <= i == 4;
			i_ready_drive_sel <= i == 4;
			@(posedge i_clk);
			i_chan_restart <= 1'b0;
			if (i < 4) begin
				push8(24'h100);
				wait_data_ready_n(1'b0, n);
			end else begin
				chk("idle enable", {31'h0, o_data_ready_oe}, 32'h0);
				push(0, 24'h200, ok);
				wait_data_ready_n(1'b0, n);
				wait_data_ready_n(1'b1, n);
				chk("pulse width", n, 4);
			end
			spi_host_model_i.frame(16'h0, 24);
			repeat (8) @(posedge i_clk);
			chk("ready after read", {31'h0, data_ready_n_line}, 32'h1);
		end
		i_ready_format_sel <= 1'b0;
		i_ready_drive_sel <= 1'b0;
		$display("data ready test done");
	endtask

	task automatic t_fill;
		logic ok;
		int   i;
		@(posedge i_clk);
		i_chan_restart <= 1'b1;
		@(posedge i_clk);
		i_chan_restart <= 1'b0;
		ok = 1'b1;
		for (i = 0; i < 40 && ok; i++)
			push(i % 8, smp(i % 8, 24'(i / 8)), ok);
		chk("buffer refuses", {31'h0, ok}, 32'h0);
		for (int f = 0; f < 4; f++) begin
			chk("flags held", {24'h0, o_status_new}, 32'hff);
			spi_host_model_i.frame(16'h0, 24);
			repeat (8) @(posedge i_clk);
			g = spi_host_model_i.got;
			for (int c = 0; c < 8; c++)
				chk("drained data", g[c + 1], fmt(2'h1, smp(c, 24'(f))));
		end
		$display("buffer test done");
	endtask

	task automatic t_timeout;
		logic [31:0] r;
		int          n0;
		@(posedge i_clk);
		i_timeout_en <= 1'b1;
		spi_host_model_i.sel(1'b0);
		spi_host_model_i.shift(32'h5a, 8, r);
		repeat (4600) @(posedge i_clk);
		n0 = ncmd;
		spi_host_model_i.frame(16'h0777, 24);
		repeat (8) @(posedge i_clk);
		chk("frame count", ncmd, n0 + 1);
		chk("command", {16'h0, last_cmd}, 32'h0777);
		$display("timeout test done");
	endtask

	initial begin
		repeat (20) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_clk);
		t_reset;
		t_frames;
		t_abort;
		t_ready;
		t_fill;
		t_timeout;
		results;
	end

	initial begin
		repeat (90000) @(posedge i_clk);
		miscompares++;
		results;
	end
endmodule
